/* File: mjk_defs.svh */
// Constants for the multi-panel jog keypad manager.
// What this block does
// [R1] Each panel holds fifteen jog-key entries; entries without a fitted key are ignored.
// [R2] Signed entry -16..+16 jogs the named logic axis in the direction of its sign.
// [R3] Unsigned entry 1..16 selects the axis only; a direction key supplies direction.
// [R4] Plus or minus entry supplies only the direction for the selected axis.
// [R5] Rapid-coded entry acts as the rapid-traverse key while jogging.
// [R6] Axis-with-direction and axis-only keys may be mixed on one keypad.
// [R7] Each panel holds sixteen user-key entries; entries without a fitted key are ignored.
// [R8] User keys with a jog function behave as jog keys and obey the jog type.
// [R9] The global key map copies the pressed-key bits of the last panel used.
// [R10] With one panel fitted the global key map equals the first panel's map.
// [R11] Each panel has its own pressed-key map, index zero being the first panel.
// [R12] Global inhibit masks disable a key or switch position on every panel.
// [R13] Per-panel inhibit masks disable a key or switch position on that panel only.
// [R14] An inhibited override position applies the lowest non-inhibited position instead.
// [R15] With every override position inhibited the override applied is zero percent.
// [R16] Global lamp masks light the matching key LED on every panel.
// [R17] Per-panel lamp masks light that panel's key LEDs only.
// [R18] Route code 0 restores configured channel, 1..4 fix channel, FF follows active.
// [R19] Configuration tables are indexed by panel order, base table for the first.
// [R20] Panels are numbered by ascending bus address, lowest address first.
// [R21] A change of active panel refreshes its maps and the global ones from it.
// [R22] Key bits are sampled every clock and clear when the key is released.
// [R23] After reset inhibit and lamp outputs are zero, every panel channel holds the CFG_CHANNEL parameter.
`ifndef MJK_DEFS_SVH
`define MJK_DEFS_SVH
`define MJK_NUM_PANELS 8
`define MJK_JOG_KEYS 15
`define MJK_USER_KEYS 16
`define MJK_KEYMAP_W 64
`define MJK_MASK_W 32
`define MJK_ENTRY_W 8
`define MJK_IDX_W 5
`define MJK_USER_BASE 5'h10
`define MJK_LAST_IDX 5'h1F
`define MJK_CHAN_W 8
`define MJK_ROUTE_CFG 8'h00
`define MJK_ROUTE_MAX_CH 8'h04
`define MJK_ROUTE_ACTIVE 8'hFF
`define MJK_FRO_POSITIONS 23
`define MJK_FRO_POS_W 5
`define MJK_FRO_MAX_PCT 120
`define MJK_PCT_W 8
`define MJK_PCT_ZERO 8'h00
`define MJK_KIND_MSB 7
`define MJK_KIND_LSB 5
`define MJK_NEG_BIT 4
`define MJK_AXIS_MSB 3
`endif

/* File: mjk_fro_pick.sv */
// Feedrate override position resolver that skips inhibited positions.
`timescale 1ns/1ps
`default_nettype none
`include "mjk_defs.svh"
module mjk_fro_pick
	import mjk_pkg::*;
#(
	parameter int NPOS = `MJK_FRO_POSITIONS,
	parameter int MAX_PCT = `MJK_FRO_MAX_PCT
)(
	input wire logic clk_sys_i, // System clock, used by the checks only.
	input wire logic reset_i, // Reset, used by the checks only.
	input wire logic [`MJK_FRO_POS_W-1:0] pos_i, // Selector position.
	input wire logic [NPOS-1:0] inhibit_i, // Inhibited positions.
	output logic [`MJK_PCT_W-1:0] pct_o // Override percent to apply.
);
	function automatic logic [`MJK_PCT_W-1:0] pct_of(input int p);
		pct_of = `MJK_PCT_W'((p * MAX_PCT) / (NPOS - 1));
	endfunction

	int low_ok;

	always_comb
	begin
		low_ok = NPOS;
		for (int i = NPOS - 1; i >= 0; i--)
		begin
			if (!inhibit_i[i])
			begin
				low_ok = i;
			end
		end
		if (int'(pos_i) < NPOS && !inhibit_i[pos_i])
		begin
			pct_o = pct_of(int'(pos_i));
		end
		else if (low_ok < NPOS)
		begin
			pct_o = pct_of(low_ok); // R14
		end
		else
		begin
			pct_o = `MJK_PCT_ZERO; // R15
		end
	end

	chk_fro_all_off: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R15
		(&inhibit_i) |-> pct_o == `MJK_PCT_ZERO)
		else $error("override not zero with all positions inhibited");
	chk_fro_lowest: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R14
		(inhibit_i[pos_i] && !inhibit_i[0]) |-> pct_o == pct_of(0))
		else $error("inhibited position did not fall back to lowest allowed");
endmodule
`default_nettype wire

/* File: mjk_keypad.sv */
// Multi-panel jog keypad manager: key maps, inhibits, lamps, routing and jog decode.
`timescale 1ns/1ps
`default_nettype none
`include "mjk_defs.svh"
module mjk_keypad
	import mjk_pkg::*;
#(
	parameter int NP = `MJK_NUM_PANELS,
	parameter logic [`MJK_CHAN_W-1:0] CFG_CHANNEL = `MJK_CHAN_W'(1)
)(
	input wire logic clk_sys_i, // System clock.
	input wire logic reset_i, // Asynchronous reset, active high.
	input wire logic [3:0] panel_count_i, // Number of fitted panels, 1 to NP.
	input wire mjk_keymap_type [NP-1:0] key_raw_i, // Raw key state, panel 0 lowest address.
	input wire logic [NP-1:0][`MJK_FRO_POS_W-1:0] fro_pos_i, // Override selector positions.
	input wire logic [NP-1:0][3:0] jog_fitted_i, // Jog keys fitted per panel.
	input wire logic [NP-1:0][4:0] user_fitted_i, // User keys fitted per panel.
	input wire mjk_inhibit_type glb_inhibit_i, // Global inhibit masks.
	input wire mjk_inhibit_type [NP-1:0] pnl_inhibit_i, // Per-panel inhibit masks.
	input wire mjk_lamp_type glb_lamp_i, // Global lamp masks.
	input wire mjk_lamp_type [NP-1:0] pnl_lamp_i, // Per-panel lamp masks.
	input wire logic [NP-1:0][`MJK_CHAN_W-1:0] route_i, // Channel routing codes.
	input wire logic [NP-1:0][`MJK_CHAN_W-1:0] cfg_channel_i, // Configured channels.
	input wire logic [`MJK_CHAN_W-1:0] active_channel_i, // Currently active channel.
	input wire logic jog_type_i, // Jog type: 1 keeps the axis selection.
	input wire mjk_cfg_wr_type cfg_wr_i, // Configuration table write.
	output mjk_keymap_type [NP-1:0] panel_key_map_o, // Pressed keys per panel.
	output mjk_keymap_type global_key_map_o, // Pressed keys of the last panel used.
	output logic [2:0] active_panel_o, // Last panel used.
	output mjk_lamp_type [NP-1:0] lamp_o, // Key LEDs per panel.
	output mjk_inhibit_type active_inhibit_o, // Inhibits in force on the last panel used.
	output logic [NP-1:0][`MJK_CHAN_W-1:0] panel_channel_o, // Channel served by each panel.
	output mjk_jog_cmd_type jog_cmd_o, // Decoded jog command.
	output logic [`MJK_PCT_W-1:0] fro_pct_o // Applied feedrate override percent.
);
	typedef struct packed {
		mjk_keymap_type [NP-1:0] key_map;
		mjk_keymap_type global_map;
		logic [2:0] active;
		mjk_lamp_type [NP-1:0] lamp;
		mjk_inhibit_type inhibit;
		logic [NP-1:0][`MJK_CHAN_W-1:0] channel;
		logic [`MJK_IDX_W-1:0] scan_idx;
		logic [`MJK_IDX_W-1:0] rd_idx;
		logic rd_ok;
		logic ad_hit;
		logic [3:0] ad_axis;
		logic ad_neg;
		logic ao_hit;
		logic [3:0] ao_axis;
		logic plus;
		logic minus;
		logic rapid;
		logic sel_held;
		logic [3:0] sel_axis;
		mjk_jog_cmd_type jog;
		logic [`MJK_PCT_W-1:0] pct;
	} mjk_state_type;

	mjk_state_type state_ff;
	mjk_state_type nxt_state;
	mjk_entry_type rd_entry;
	logic [`MJK_PCT_W-1:0] fro_pct;
	mjk_inhibit_type act_inh;
	mjk_keymap_type [NP-1:0] eff_keys;
	mjk_keymap_type [NP-1:0] key_mask;
	logic [NP-1:0] pnl_used;

	// Tables are addressed by panel order, so the first panel owns the base table.
	mjk_table_mem #(
		.AW(3 + `MJK_IDX_W),
		.DW(`MJK_ENTRY_W)
	) u_table (
		.clk_sys_i(clk_sys_i),
		.we_i(cfg_wr_i.we),
		.waddr_i({cfg_wr_i.panel, cfg_wr_i.idx}), // R19
		.wdata_i(cfg_wr_i.entry),
		.raddr_i({state_ff.active, state_ff.scan_idx}), // R19
		.rdata_o(rd_entry)
	);

	assign act_inh.a = glb_inhibit_i.a | pnl_inhibit_i[state_ff.active].a;
	assign act_inh.b = glb_inhibit_i.b | pnl_inhibit_i[state_ff.active].b;
	assign act_inh.c = glb_inhibit_i.c | pnl_inhibit_i[state_ff.active].c;

	mjk_fro_pick #(
		.NPOS(`MJK_FRO_POSITIONS),
		.MAX_PCT(`MJK_FRO_MAX_PCT)
	) u_fro (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.pos_i(fro_pos_i[state_ff.active]),
		.inhibit_i(act_inh.c[`MJK_FRO_POSITIONS-1:0]), // R12 R13
		.pct_o(fro_pct)
	);

	// A panel counts as used when a non-inhibited key changes on it.
	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++)
		begin : g_panel
			assign key_mask[gp] = {glb_inhibit_i.b, glb_inhibit_i.a} | // R12
				{pnl_inhibit_i[gp].b, pnl_inhibit_i[gp].a}; // R13
			assign eff_keys[gp] = key_raw_i[gp] & ~key_mask[gp];
			assign pnl_used[gp] = (gp < int'(panel_count_i)) &&
				(eff_keys[gp] != (state_ff.key_map[gp] & ~key_mask[gp]));
		end
	endgenerate

	always_comb
	begin
		logic [2:0] new_act;
		logic changed;
		logic fitted;
		logic key_on;
		mjk_keymap_type act_eff;
		new_act = state_ff.active;
		changed = 1'b0;
		fitted = 1'b0;
		key_on = 1'b0;
		act_eff = '0;
		nxt_state = state_ff;

		// Raw key state is taken every clock, so a released key clears its bit.
		nxt_state.key_map = key_raw_i; // R22 R11
		for (int p = NP - 1; p >= 0; p--)
		begin
			if (pnl_used[p])
			begin
				new_act = 3'(p); // R20
			end
		end
		if (panel_count_i <= 4'h1)
		begin
			new_act = 3'h0; // R10
		end
		changed = new_act != state_ff.active;
		nxt_state.active = new_act;
		nxt_state.global_map = key_raw_i[new_act]; // R9 R21
		nxt_state.inhibit.a = glb_inhibit_i.a | pnl_inhibit_i[new_act].a; // R21
		nxt_state.inhibit.b = glb_inhibit_i.b | pnl_inhibit_i[new_act].b;
		nxt_state.inhibit.c = glb_inhibit_i.c | pnl_inhibit_i[new_act].c;

		for (int p = 0; p < NP; p++)
		begin
			nxt_state.lamp[p].low = glb_lamp_i.low | pnl_lamp_i[p].low; // R16 R17
			nxt_state.lamp[p].high = glb_lamp_i.high | pnl_lamp_i[p].high; // R16 R17
			if (route_i[p] == `MJK_ROUTE_ACTIVE)
			begin
				nxt_state.channel[p] = active_channel_i; // R18
			end
			else if (route_i[p] != `MJK_ROUTE_CFG && route_i[p] <= `MJK_ROUTE_MAX_CH)
			begin
				nxt_state.channel[p] = route_i[p]; // R18
			end
			else
			begin
				nxt_state.channel[p] = cfg_channel_i[p]; // R18
			end
		end

		// Scan of the active panel's tables; a read lands one cycle after its address.
		act_eff = eff_keys[state_ff.active];
		nxt_state.scan_idx = state_ff.scan_idx + `MJK_IDX_W'(1);
		nxt_state.rd_idx = state_ff.scan_idx;
		nxt_state.rd_ok = 1'b1;
		if (state_ff.rd_idx < `MJK_USER_BASE)
		begin
			fitted = state_ff.rd_idx < `MJK_IDX_W'(`MJK_JOG_KEYS) &&
				state_ff.rd_idx[3:0] < jog_fitted_i[state_ff.active]; // R1
		end
		else
		begin
			fitted = {1'b0, state_ff.rd_idx[3:0]} < user_fitted_i[state_ff.active]; // R7 R8
		end
		key_on = state_ff.rd_ok && fitted && act_eff[state_ff.rd_idx];
		if (key_on)
		begin
			case (rd_entry.kind)
				MJK_KIND_AXIS_DIR:
				begin
					if (!state_ff.ad_hit)
					begin
						nxt_state.ad_hit = 1'b1; // R2 R6
						nxt_state.ad_axis = rd_entry.axis_m1;
						nxt_state.ad_neg = rd_entry.neg;
					end
				end
				MJK_KIND_AXIS_ONLY:
				begin
					nxt_state.ao_hit = 1'b1; // R3 R6
					nxt_state.ao_axis = rd_entry.axis_m1;
				end
				MJK_KIND_DIR_PLUS:
				begin
					nxt_state.plus = 1'b1; // R4
				end
				MJK_KIND_DIR_MINUS:
				begin
					nxt_state.minus = 1'b1; // R4
				end
				MJK_KIND_RAPID:
				begin
					nxt_state.rapid = 1'b1; // R5
				end
				default:
				begin
					nxt_state.rd_ok = 1'b1;
				end
			endcase
		end

		// Results use this pass's hits, the last entry included, before they are cleared.
		if (state_ff.rd_ok && state_ff.rd_idx == `MJK_LAST_IDX)
		begin
			if (nxt_state.ao_hit)
			begin
				nxt_state.sel_held = 1'b1;
				nxt_state.sel_axis = nxt_state.ao_axis;
			end
			else if (!jog_type_i)
			begin
				nxt_state.sel_held = 1'b0; // R8
			end
			if (nxt_state.ad_hit)
			begin
				nxt_state.jog.valid = 1'b1; // R2
				nxt_state.jog.axis_m1 = nxt_state.ad_axis;
				nxt_state.jog.neg = nxt_state.ad_neg;
			end
			else
			begin
				nxt_state.jog.valid = nxt_state.sel_held && (nxt_state.plus ^ nxt_state.minus); // R3 R4
				nxt_state.jog.axis_m1 = nxt_state.sel_axis;
				nxt_state.jog.neg = nxt_state.minus;
			end
			nxt_state.jog.rapid = nxt_state.rapid && nxt_state.jog.valid; // R5
			nxt_state.ad_hit = 1'b0;
			nxt_state.ao_hit = 1'b0;
			nxt_state.plus = 1'b0;
			nxt_state.minus = 1'b0;
			nxt_state.rapid = 1'b0;
		end

		if (changed)
		begin
			nxt_state.scan_idx = '0; // R21
			nxt_state.rd_ok = 1'b0;
			nxt_state.ad_hit = 1'b0;
			nxt_state.ao_hit = 1'b0;
			nxt_state.plus = 1'b0;
			nxt_state.minus = 1'b0;
			nxt_state.rapid = 1'b0;
			nxt_state.sel_held = 1'b0;
		end
		nxt_state.pct = fro_pct;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_ff <= '0; // R23
			for (int p = 0; p < NP; p++)
			begin
				state_ff.channel[p] <= CFG_CHANNEL; // R23
			end
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign panel_key_map_o = state_ff.key_map;
	assign global_key_map_o = state_ff.global_map;
	assign active_panel_o = state_ff.active;
	assign lamp_o = state_ff.lamp;
	assign active_inhibit_o = state_ff.inhibit;
	assign panel_channel_o = state_ff.channel;
	assign jog_cmd_o = state_ff.jog;
	assign fro_pct_o = state_ff.pct;

	chk_key_sample: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R22
		##1 panel_key_map_o[0] == $past(key_raw_i[0]))
		else $error("panel key map does not follow the keys");
	chk_global_copy: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R9
		##1 global_key_map_o == panel_key_map_o[active_panel_o])
		else $error("global key map differs from the last panel used");
	chk_one_panel: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R10
		panel_count_i == 4'h1 |=> global_key_map_o == panel_key_map_o[0])
		else $error("single panel map mismatch");
	chk_route_fixed: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R18
		(route_i[0] != `MJK_ROUTE_CFG && route_i[0] <= `MJK_ROUTE_MAX_CH)
		|=> panel_channel_o[0] == $past(route_i[0]))
		else $error("fixed channel routing wrong");
	chk_route_active: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R18
		route_i[1] == `MJK_ROUTE_ACTIVE |=> panel_channel_o[1] == $past(active_channel_i))
		else $error("active channel routing wrong");
	chk_route_cfg: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R18
		route_i[0] == `MJK_ROUTE_CFG |=> panel_channel_o[0] == $past(cfg_channel_i[0]))
		else $error("configured routing not restored");
	chk_lamp_merge: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R16
		glb_lamp_i.low[0] |=> lamp_o[NP-1].low[0] && lamp_o[0].low[0])
		else $error("global lamp not shown on all panels");
	chk_scan_restart: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R21
		(nxt_state.active != state_ff.active) |=> state_ff.scan_idx == '0 && !state_ff.rd_ok)
		else $error("scan not restarted on panel change");
	chk_jog_dir: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R4
		(state_ff.rd_ok && state_ff.rd_idx == `MJK_LAST_IDX && !state_ff.ad_hit &&
		state_ff.minus && !state_ff.plus && !eff_keys[state_ff.active][`MJK_LAST_IDX])
		|=> !jog_cmd_o.valid || jog_cmd_o.neg)
		else $error("minus key did not give a negative jog");
	chk_ad_result: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R2
		(state_ff.rd_ok && state_ff.rd_idx == `MJK_LAST_IDX && state_ff.ad_hit)
		|=> jog_cmd_o.valid && jog_cmd_o.axis_m1 == $past(state_ff.ad_axis))
		else $error("pending axis key did not give a jog command");
	chk_unfitted_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
		(state_ff.rd_ok && state_ff.rd_idx == `MJK_IDX_W'(`MJK_JOG_KEYS) &&
		nxt_state.active == state_ff.active)
		|=> state_ff.ad_hit == $past(state_ff.ad_hit) &&
		state_ff.ao_hit == $past(state_ff.ao_hit))
		else $error("unused table slot changed the jog selection");
	chk_sel_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R21
		(nxt_state.active != state_ff.active) |=> !state_ff.sel_held)
		else $error("axis selection kept across a panel change");
	chk_inh_active: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R13
		##1 active_panel_o == 3'h0 |->
		active_inhibit_o.a == ($past(glb_inhibit_i.a) | $past(pnl_inhibit_i[0].a)))
		else $error("inhibits of the first panel not in force");
	chk_lamp_own: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R17
		##1 lamp_o[NP-1] == ($past(glb_lamp_i) | $past(pnl_lamp_i[NP-1])))
		else $error("last panel lamps wrong");
	chk_map_last: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R11
		##1 panel_key_map_o[NP-1] == $past(key_raw_i[NP-1]))
		else $error("last panel key map does not follow its keys");
	chk_single_active: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R10
		panel_count_i <= 4'h1 |=> active_panel_o == 3'h0)
		else $error("single panel not kept active");
	chk_lowest_wins: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R20
		pnl_used[0] |=> active_panel_o == 3'h0)
		else $error("lowest address panel did not win");
	chk_route_spare: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R18
		(route_i[0] > `MJK_ROUTE_MAX_CH && route_i[0] != `MJK_ROUTE_ACTIVE)
		|=> panel_channel_o[0] == $past(cfg_channel_i[0]))
		else $error("unused routing code did not restore configured channel");
endmodule
`default_nettype wire

/* File: mjk_panel_model.sv */
// Behavioural model of the operator jog panels that feed the keypad manager.
`timescale 1ns/1ps
`default_nettype none
module mjk_panel_model
	import mjk_pkg::*;
(
	input wire logic clk_sys_i, // System clock.
	output mjk_keymap_type [7:0] key_raw_o, // Key state per panel, one means pressed.
	output logic [7:0][4:0] fro_pos_o, // Override selector per panel.
	output logic [7:0][3:0] jog_fitted_o, // Jog keys fitted per panel.
	output logic [7:0][4:0] user_fitted_o // User keys fitted per panel.
);
	initial
	begin
		key_raw_o = '0;
		fro_pos_o = '0;
		jog_fitted_o = {8{4'hF}};
		user_fitted_o = {8{5'h10}};
	end
	task automatic key(input int p, input int b, input logic v);
		@(posedge clk_sys_i);
		key_raw_o[p][b] <= v;
	endtask
	task automatic fro(input int p, input logic [4:0] pos);
		@(posedge clk_sys_i);
		fro_pos_o[p] <= pos;
	endtask
	task automatic fit(input int p, input logic [3:0] j, input logic [4:0] u);
		@(posedge clk_sys_i);
		jog_fitted_o[p] <= j;
		user_fitted_o[p] <= u;
	endtask
endmodule
`default_nettype wire

/* File: mjk_pkg.sv */
// Types shared by the jog keypad manager modules.
`default_nettype none
`include "mjk_defs.svh"
package mjk_pkg;
	typedef logic [`MJK_KEYMAP_W-1:0] mjk_keymap_type;
	typedef enum logic [2:0] {
		MJK_KIND_NONE,
		MJK_KIND_AXIS_DIR,
		MJK_KIND_AXIS_ONLY,
		MJK_KIND_DIR_PLUS,
		MJK_KIND_DIR_MINUS,
		MJK_KIND_RAPID
	} mjk_kind_type;
	typedef struct packed {
		logic [`MJK_MASK_W-1:0] c;
		logic [`MJK_MASK_W-1:0] b;
		logic [`MJK_MASK_W-1:0] a;
	} mjk_inhibit_type;
	typedef struct packed {
		logic [`MJK_MASK_W-1:0] high;
		logic [`MJK_MASK_W-1:0] low;
	} mjk_lamp_type;
	typedef struct packed {
		mjk_kind_type kind;
		logic neg;
		logic [3:0] axis_m1;
	} mjk_entry_type;
	typedef struct packed {
		logic we;
		logic [2:0] panel;
		logic [`MJK_IDX_W-1:0] idx;
		mjk_entry_type entry;
	} mjk_cfg_wr_type;
	typedef struct packed {
		logic valid;
		logic [3:0] axis_m1;
		logic neg;
		logic rapid;
	} mjk_jog_cmd_type;
endpackage
`default_nettype wire

/* File: mjk_table_mem.sv */
// Key configuration table memory with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "mjk_defs.svh"
module mjk_table_mem
	import mjk_pkg::*;
#(
	parameter int AW = 8,
	parameter int DW = `MJK_ENTRY_W
)(
	input wire logic clk_sys_i, // System clock.
	input wire logic we_i, // Write strobe.
	input wire logic [AW-1:0] waddr_i, // Write address.
	input wire logic [DW-1:0] wdata_i, // Write data.
	input wire logic [AW-1:0] raddr_i, // Read address.
	output logic [DW-1:0] rdata_o // Read data, one cycle after the address.
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_sys_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

/* File: tb_multi_panel_jog_keypad.sv */
// Self-checking testbench for the multi-panel jog keypad manager.
`timescale 1ns/1ps
`default_nettype none
module tb_multi_panel_jog_keypad
	import mjk_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] panel_count = 4'h8;
	mjk_keymap_type [7:0] key_raw;
	logic [7:0][4:0] fro_pos;
	logic [7:0][3:0] jog_fit;
	logic [7:0][4:0] user_fit;
	mjk_inhibit_type glb_inh = '0;
	mjk_inhibit_type [7:0] pnl_inh = '0;
	mjk_lamp_type glb_lamp = '0;
	mjk_lamp_type [7:0] pnl_lamp = '0;
	logic [7:0][7:0] route = '0;
	logic [7:0][7:0] cfg_ch = {8{8'h07}};
	logic [7:0] act_ch = 8'h03;
	logic jog_type = 1'b0;
	mjk_cfg_wr_type cfg_wr = '0;
	mjk_keymap_type [7:0] panel_key_map;
	mjk_keymap_type global_key_map;
	logic [2:0] active_panel;
	mjk_lamp_type [7:0] lamp;
	mjk_inhibit_type active_inhibit;
	logic [7:0][7:0] panel_channel;
	mjk_jog_cmd_type jog_cmd;
	logic [7:0] fro_pct;
	int errors = 0;
	int checks_done = 0;
	logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hFF};
	logic [7:0] exp_ch [7] = '{8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h03};
	logic [4:0] pv [5] = '{5'h16, 5'h0B, 5'h01, 5'h05, 5'h05};
	logic [22:0] cv [5] = '{23'h0, 23'h0, 23'h7, 23'h7FFFFF, 23'h20};
	logic [7:0] pct [5] = '{8'h78, 8'h3C, 8'h10, 8'h00, 8'h00};

	mjk_panel_model pm (
		.clk_sys_i(clk_sys_i),
		.key_raw_o(key_raw),
		.fro_pos_o(fro_pos),
		.jog_fitted_o(jog_fit),
		.user_fitted_o(user_fit)
	);

	mjk_keypad uut (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.panel_count_i(panel_count),
		.key_raw_i(key_raw),
		.fro_pos_i(fro_pos),
		.jog_fitted_i(jog_fit),
		.user_fitted_i(user_fit),
		.glb_inhibit_i(glb_inh),
		.pnl_inhibit_i(pnl_inh),
		.glb_lamp_i(glb_lamp),
		.pnl_lamp_i(pnl_lamp),
		.route_i(route),
		.cfg_channel_i(cfg_ch),
		.active_channel_i(act_ch),
		.jog_type_i(jog_type),
		.cfg_wr_i(cfg_wr),
		.panel_key_map_o(panel_key_map),
		.global_key_map_o(global_key_map),
		.active_panel_o(active_panel),
		.lamp_o(lamp),
		.active_inhibit_o(active_inhibit),
		.panel_channel_o(panel_channel),
		.jog_cmd_o(jog_cmd),
		.fro_pct_o(fro_pct)
	);

	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic cfg(input logic [2:0] p, input logic [4:0] idx, input mjk_kind_type k,
		input logic n, input logic [3:0] a);
		@(posedge clk_sys_i);
		cfg_wr <= '{1'b1, p, idx, '{k, n, a}};
		@(posedge clk_sys_i);
		cfg_wr.we <= 1'b0;
	endtask

	// The scan revisits the table every 32 cycles, so 70 cycles cover two full passes.
	task automatic jog(input logic [6:0] exp);
		tick(70);
		chk(96'(jog_cmd), 96'(exp));
	endtask

	task automatic summarize();
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#200000;
		errors++;
		summarize();
	end

	initial
	begin
		tick(3);
		chk(96'(lamp[0]), 96'h0);
		chk(96'(active_inhibit), 96'h0);
		chk(96'(panel_channel[4]), 96'h1);
		@(posedge clk_sys_i);
		reset_i <= 1'b0;
		tick(2);
		chk(96'(panel_channel[4]), 96'h7);
		pm.key(2, 40, 1'b1);
		tick(2);
		chk(96'(panel_key_map[2]), 96'h0000_0100_0000_0000);
		chk(96'(global_key_map), 96'h0000_0100_0000_0000);
		chk(96'(active_panel), 96'h2);
		chk(96'(panel_key_map[5]), 96'h0);
		pm.key(5, 8, 1'b1);
		tick(2);
		chk(96'(active_panel), 96'h5);
		chk(96'(global_key_map), 96'h100);
		pm.key(2, 40, 1'b0);
		tick(2);
		chk(96'(panel_key_map[2]), 96'h0);
		chk(96'(active_panel), 96'h2);
		pm.key(5, 8, 1'b0);
		@(posedge clk_sys_i);
		glb_inh.a <= 32'h1;
		pnl_inh[5].b <= 32'h80;
		glb_lamp.low <= 32'h1;
		pnl_lamp[3].high <= 32'h8000_0000;
		tick(2);
		chk(96'(active_inhibit), {32'h0, 32'h80, 32'h1});
		chk(96'(lamp[3]), 96'h8000_0000_0000_0001);
		chk(96'(lamp[6]), 96'h1);
		pm.key(2, 9, 1'b1);
		tick(2);
		chk(96'(active_inhibit), {32'h0, 32'h0, 32'h1});
		@(posedge clk_sys_i);
		glb_inh <= '0;
		pnl_inh <= '0;
		panel_count <= 4'h1;
		pm.key(3, 8, 1'b1);
		pm.key(0, 12, 1'b1);
		tick(2);
		chk(96'(global_key_map), 96'h1000);
		chk(96'(active_panel), 96'h0);
		@(posedge clk_sys_i);
		panel_count <= 4'h8;
		pm.key(0, 12, 1'b0);
		pm.key(3, 8, 1'b0);
		pm.key(2, 9, 1'b0);
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk_sys_i);
			route <= {8{codes[i]}};
			tick(2);
			chk(96'(panel_channel[6]), 96'(exp_ch[i]));
		end
		pm.fit(1, 4'h4, 5'h10);
		cfg(3'h0, 5'h00, MJK_KIND_AXIS_DIR, 1'b0, 4'h9);
		cfg(3'h1, 5'h00, MJK_KIND_AXIS_DIR, 1'b1, 4'h4);
		cfg(3'h1, 5'h01, MJK_KIND_AXIS_ONLY, 1'b0, 4'h1);
		cfg(3'h1, 5'h02, MJK_KIND_DIR_PLUS, 1'b0, 4'h0);
		cfg(3'h1, 5'h03, MJK_KIND_RAPID, 1'b0, 4'h0);
		cfg(3'h1, 5'h04, MJK_KIND_AXIS_DIR, 1'b0, 4'h6);
		cfg(3'h1, 5'h10, MJK_KIND_AXIS_DIR, 1'b0, 4'hF);
		pm.key(1, 0, 1'b1);
		jog({1'b1, 4'h4, 1'b1, 1'b0});
		@(posedge clk_sys_i);
		glb_inh.a <= 32'h1;
		jog(7'h0);
		@(posedge clk_sys_i);
		glb_inh.a <= 32'h0;
		pm.key(1, 0, 1'b0);
		pm.key(1, 1, 1'b1);
		pm.key(1, 2, 1'b1);
		jog({1'b1, 4'h1, 1'b0, 1'b0});
		pm.key(1, 3, 1'b1);
		jog({1'b1, 4'h1, 1'b0, 1'b1});
		pm.key(1, 1, 1'b0);
		pm.key(1, 2, 1'b0);
		pm.key(1, 3, 1'b0);
		pm.key(1, 4, 1'b1);
		jog({1'b0, 4'h1, 1'b0, 1'b0});
		pm.key(1, 4, 1'b0);
		pm.key(1, 16, 1'b1);
		jog({1'b1, 4'hF, 1'b0, 1'b0});
		cfg(3'h1, 5'h11, MJK_KIND_DIR_MINUS, 1'b0, 4'h0);
		pm.key(1, 16, 1'b0);
		jog_type <= 1'b1;
		pm.key(1, 1, 1'b1);
		jog({1'b0, 4'h1, 1'b0, 1'b0});
		pm.key(1, 1, 1'b0);
		pm.key(1, 17, 1'b1);
		jog({1'b1, 4'h1, 1'b1, 1'b0});
		for (int i = 0; i < 5; i++)
		begin
			pm.fro(1, pv[i]);
			glb_inh.c <= 32'(cv[i]);
			tick(3);
			chk(96'(fro_pct), 96'(pct[i]));
		end
		summarize();
	end
endmodule
`default_nettype wire
